//--- logic/tvi_regs.svh
// Purpose: Register offsets, field positions, reset values and exception numbers
// Assumes: Byte addresses on an 8-bit Wishbone address, one aligned word per register
// Notes: Definitions only
`ifndef TVI_REGS_SVH
`define TVI_REGS_SVH
`define TVI_A_TCTL 8'h00
`define TVI_A_TRLD 8'h04
`define TVI_A_TCUR 8'h08
`define TVI_A_ENSET 8'h10
`define TVI_A_ENCLR 8'h14
`define TVI_A_PNSET 8'h18
`define TVI_A_PNCLR 8'h1c
`define TVI_A_TYPE 8'h20
`define TVI_A_PRLO 8'h24
`define TVI_A_PRHI 8'h28
`define TVI_A_SPRI 8'h2c
`define TVI_A_VBASE 8'h30
`define TVI_A_STAT 8'h34
`define TVI_TCTL_EN 0
`define TVI_TCTL_INT 1
`define TVI_TCTL_SRC 2
`define TVI_TCTL_WRAP 16
`define TVI_VBASE_RST 32'h0000_0000
`define TVI_EXC_NMI 6'h02
`define TVI_EXC_TICK 6'h0f
`define TVI_EXC_IRQ0 6'h10
`define TVI_PRIO_NONE 3'h7
`define TVI_LAST_WORD 3'h7
`define TVI_FRAME_BYTES 32'h0000_0020
`endif

//--- logic/tvi_pkg.sv
// Purpose: Shared types of the tick timer and vectored interrupt unit
// Assumes: Nothing beyond the register header
// Notes: Frame words are packed so that index 0 is r0
package tvi_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_STACK, ST_VFETCH, ST_RUN, ST_UNSTACK} tvi_state_t;
  typedef struct packed {
    logic [31:0] psr;
    logic [31:0] pc;
    logic [31:0] lr;
    logic [31:0] r12;
    logic [31:0] r3;
    logic [31:0] r2;
    logic [31:0] r1;
    logic [31:0] r0;
  } tvi_frame_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tvi_mreq_t;
  typedef struct packed {
    logic src;
    logic inten;
    logic en;
  } tvi_tctl_t;
endpackage

//--- logic/tvi_tick.sv
// Purpose: System tick down-counter with wrap flag and tick request
// Assumes: ext_tick is synchronous to sys_clk
// Notes: Current value has no reset by design
`timescale 1ns/1ps
`include "tvi_regs.svh"
module tvi_tick import tvi_pkg::*; #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire tvi_tctl_t ctl,
  input wire logic [W-1:0] reload,
  input wire logic cur_clr,
  input wire logic flag_rd,
  input wire logic ext_tick,
  // Status
  output logic [W-1:0] cur_r,
  output logic wrap_r,
  output logic tick_req_r
);
  logic ext_d_r;
  logic tick_en;
  logic zero_hit;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_tick;
    end
  end

  // External tick counts on its rising edge only
  assign tick_en = ctl.src ? 1'b1 : (ext_tick & ~ext_d_r);
  assign zero_hit = ctl.en & tick_en & (cur_r == W'(1));

  // Left out of reset so software must clear it before enabling
  always_ff @(posedge sys_clk) begin
    if (cur_clr) begin
      cur_r <= '0;
    end else if (ctl.en && tick_en) begin
      cur_r <= (cur_r == '0) ? reload : cur_r - W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrap_r <= 1'b0;
    end else if (zero_hit) begin
      wrap_r <= 1'b1;
    end else if (flag_rd) begin
      wrap_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_req_r <= 1'b0;
    end else begin
      tick_req_r <= zero_hit & ctl.inten;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_tick_clear: assert property (cur_clr |=> cur_r == '0)
    else $error("tick current value not cleared by write");
  a_tick_reload: assert property (ctl.en && tick_en && !cur_clr && cur_r == '0
    |=> cur_r == $past(reload))
    else $error("tick counter did not reload at zero");
  a_tick_wrap: assert property (zero_hit |=> wrap_r && tick_req_r == $past(ctl.inten))
    else $error("wrap flag or request missing after zero");
  a_tick_rdclr: assert property (flag_rd && !zero_hit |=> !wrap_r)
    else $error("wrap flag survived a status read");
  // Only while enabled: before its first write the value is unknown
  a_tick_hold: assert property (ctl.en && !ctl.src && !(ext_tick && !ext_d_r) && !cur_clr
    |=> $stable(cur_r))
    else $error("tick counter moved without external edge");
endmodule // tvi_tick

//--- logic/tvi_top.sv
// Purpose: Nested vectored interrupt unit with system tick, Wishbone registers
// Assumes: Core gives its frame and stack pointer, memory port answers with ack
// Notes: Frame is r0-lr, pc, psr at rising addresses from the new sp
// Contract
// - Tick is 24-bit down-counter, write clears current
// - Decrement each tick, reload on edge after zero
// - Set wrap flag when counter reaches zero
// - Reading status register clears wrap flag
// - Current value is not reset
// - Zero reload keeps counter stopped at zero
// - Thirty-two request lines, four priority levels each
// - Tick and lines have programmable priority
// - Preempt only for strictly higher priority
// - Handler address fetched from vector table
// - Stack eight core words during vector fetch (the code stacks all eight words first, then fetches the vector)
// - Handler end unstacks and resumes execution
// - Pending at handler end chains without unstacking
// - Higher request during entry takes over directly
// - Handlers run in handler mode
// - Each line is level or pulse sensitive
// - Separate non-maskable interrupt input
// - Tick clocked by core or external tick
`timescale 1ns/1ps
`include "tvi_regs.svh"
module tvi_top import tvi_pkg::*; #(
  parameter int DEPTH = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Interrupt sources
  input wire logic [31:0] irq_line,
  input wire logic nmi_line,
  input wire logic ext_tick,
  // Core side
  input wire tvi_frame_t core_frame,
  input wire logic [31:0] core_sp,
  input wire logic exc_return,
  output logic hnd_start,
  output logic [31:0] hnd_addr,
  output logic hnd_mode,
  output logic [5:0] exc_num,
  output logic rest_vld,
  output logic [2:0] rest_idx,
  output logic [31:0] rest_data,
  output logic resume,
  output logic [31:0] sp_out,
  // Memory master
  output tvi_mreq_t mreq,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  localparam int NIRQ = 32;

  tvi_tctl_t tctl_r;
  logic [23:0] trld_r, tcur;
  logic twrap, tick_req;
  logic [NIRQ-1:0] en_r, pend_r, type_r, irq_d_r;
  logic [2*NIRQ-1:0] prio_r;
  logic [1:0] tprio_r;
  logic [31:0] vbase_r;
  logic tick_pend_r, nmi_pend_r, nmi_d_r;
  logic ack_r, acc, rd_cap, tcur_clr, flag_rd;
  logic [31:0] wm, wd, rmux;
  logic [NIRQ-1:0] hw_set, acc_irq;
  tvi_state_t state_r;
  logic [5:0] sel_n_r, best_n;
  logic [2:0] sel_p_r, best_p, run_p, pop_p;
  logic best_v, accept, pre_go, chain_go;
  logic [2:0] idx_r;
  logic [31:0] sp_r;
  logic [4:0] act_r, pop_act;
  logic [5:0] exc_stk_r [0:DEPTH-1];
  logic [2:0] depth_r;
  logic [7:0][31:0] frame_w;

  function automatic logic [2:0] top_prio(input logic [4:0] a);
    logic [2:0] p;
    p = `TVI_PRIO_NONE;
    for (int k = 4; k >= 0; k--) begin
      if (a[k]) p = 3'(k);
    end
    return p;
  endfunction

  // Wishbone: ack one cycle after the strobe, dropped the next cycle
  assign acc = wb_cyc & wb_stb & ack_r;
  assign rd_cap = wb_cyc & wb_stb & ~ack_r & ~wb_we;
  assign wm = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  assign wd = wb_dat_w & wm;
  assign wb_ack = ack_r;
  // Clearing at capture keeps a flag set in the read window for the next read
  assign flag_rd = rd_cap & (wb_adr == `TVI_A_TCTL);
  assign tcur_clr = acc & wb_we & (wb_adr == `TVI_A_TCUR) & (|wb_sel);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      wb_dat_r <= '0;
    end else begin
      ack_r <= wb_cyc & wb_stb & ~ack_r;
      if (rd_cap) wb_dat_r <= rmux;
    end
  end

  always_comb begin
    rmux = '0;
    case (wb_adr)
      `TVI_A_TCTL: begin
        rmux[`TVI_TCTL_EN] = tctl_r.en;
        rmux[`TVI_TCTL_INT] = tctl_r.inten;
        rmux[`TVI_TCTL_SRC] = tctl_r.src;
        rmux[`TVI_TCTL_WRAP] = twrap;
      end
      `TVI_A_TRLD: rmux = {8'h00, trld_r};
      `TVI_A_TCUR: rmux = {8'h00, tcur};
      `TVI_A_ENSET, `TVI_A_ENCLR: rmux = en_r;
      `TVI_A_PNSET, `TVI_A_PNCLR: rmux = pend_r;
      `TVI_A_TYPE: rmux = type_r;
      `TVI_A_PRLO: rmux = prio_r[31:0];
      `TVI_A_PRHI: rmux = prio_r[63:32];
      `TVI_A_SPRI: rmux = {30'h0, tprio_r};
      `TVI_A_VBASE: rmux = vbase_r;
      `TVI_A_STAT: rmux = {21'h0, depth_r, 1'b0, hnd_mode, exc_num};
      default: rmux = '0;
    endcase
  end

  // Software configuration, byte lanes honoured
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tctl_r <= '0;
      trld_r <= '0;
      en_r <= '0;
      type_r <= '0;
      prio_r <= '0;
      tprio_r <= '0;
      vbase_r <= `TVI_VBASE_RST;
    end else if (acc && wb_we) begin
      case (wb_adr)
        `TVI_A_TCTL: if (wb_sel[0]) tctl_r <= wb_dat_w[2:0];
        `TVI_A_TRLD: trld_r <= 24'((32'(trld_r) & ~wm) | wd);
        `TVI_A_ENSET: en_r <= en_r | wd;
        `TVI_A_ENCLR: en_r <= en_r & ~wd;
        `TVI_A_TYPE: type_r <= (type_r & ~wm) | wd;
        `TVI_A_PRLO: prio_r[31:0] <= (prio_r[31:0] & ~wm) | wd;
        `TVI_A_PRHI: prio_r[63:32] <= (prio_r[63:32] & ~wm) | wd;
        `TVI_A_SPRI: if (wb_sel[0]) tprio_r <= wb_dat_w[1:0];
        `TVI_A_VBASE: vbase_r <= (vbase_r & ~wm) | wd;
        default: ;
      endcase
    end
  end

  tvi_tick #(.W(24)) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ctl(tctl_r),
    .reload(trld_r),
    .cur_clr(tcur_clr),
    .flag_rd(flag_rd),
    .ext_tick(ext_tick),
    .cur_r(tcur),
    .wrap_r(twrap),
    .tick_req_r(tick_req)
  );

  // Pending: hardware set wins over any clear in the same cycle
  assign hw_set = (irq_line & ~type_r) | (irq_line & ~irq_d_r & type_r);
  always_comb begin
    acc_irq = '0;
    if (accept && sel_n_r >= `TVI_EXC_IRQ0) acc_irq[5'(sel_n_r - `TVI_EXC_IRQ0)] = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_d_r <= '0;
      nmi_d_r <= 1'b0;
      pend_r <= '0;
      tick_pend_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      irq_d_r <= irq_line;
      nmi_d_r <= nmi_line;
      pend_r <= (pend_r & ~acc_irq & ~((acc && wb_we && wb_adr == `TVI_A_PNCLR) ? wd : '0))
        | hw_set | ((acc && wb_we && wb_adr == `TVI_A_PNSET) ? wd : '0);
      if (tick_req) begin
        tick_pend_r <= 1'b1;
      end else if (accept && sel_n_r == `TVI_EXC_TICK) begin
        tick_pend_r <= 1'b0;
      end
      if (nmi_line && !nmi_d_r) begin
        nmi_pend_r <= 1'b1;
      end else if (accept && sel_n_r == `TVI_EXC_NMI) begin
        nmi_pend_r <= 1'b0;
      end
    end
  end

  // Arbitration: lower value wins, ties go to the lower exception number
  always_comb begin
    best_v = 1'b0;
    best_p = `TVI_PRIO_NONE;
    best_n = '0;
    if (nmi_pend_r) begin
      best_v = 1'b1;
      best_p = 3'h0;
      best_n = `TVI_EXC_NMI;
    end else begin
      if (tick_pend_r) begin
        best_v = 1'b1;
        best_p = {1'b0, tprio_r} + 3'h1;
        best_n = `TVI_EXC_TICK;
      end
      for (int i = 0; i < NIRQ; i++) begin
        if (pend_r[i] && en_r[i] && ({1'b0, prio_r[2*i +: 2]} + 3'h1) < best_p) begin
          best_v = 1'b1;
          best_p = {1'b0, prio_r[2*i +: 2]} + 3'h1;
          best_n = `TVI_EXC_IRQ0 + 6'(i);
        end
      end
    end
  end

  assign run_p = top_prio(act_r);
  assign pop_act = act_r & (act_r - 5'h1);
  assign pop_p = top_prio(pop_act);
  assign pre_go = best_v && (best_p < run_p);
  assign chain_go = best_v && (best_p < pop_p);
  assign accept = (state_r == ST_VFETCH) && mreq.req && mem_ack && !(best_v && best_p < sel_p_r);
  assign frame_w = core_frame;

  // Exception entry, handler and return sequencing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      sel_n_r <= '0;
      sel_p_r <= `TVI_PRIO_NONE;
      idx_r <= '0;
      sp_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE, ST_RUN: begin
          if (state_r == ST_RUN && exc_return) begin
            if (chain_go) begin
              state_r <= ST_VFETCH;
              sel_n_r <= best_n;
              sel_p_r <= best_p;
            end else begin
              state_r <= ST_UNSTACK;
              idx_r <= '0;
            end
          end else if (pre_go) begin
            state_r <= ST_STACK;
            sel_n_r <= best_n;
            sel_p_r <= best_p;
            idx_r <= '0;
            sp_r <= core_sp - `TVI_FRAME_BYTES;
          end
        end
        ST_STACK: begin
          if (best_v && best_p < sel_p_r) begin
            sel_n_r <= best_n;
            sel_p_r <= best_p;
          end
          if (mreq.req && mem_ack) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r == `TVI_LAST_WORD) state_r <= ST_VFETCH;
          end
        end
        ST_VFETCH: begin
          if (mreq.req && mem_ack) begin
            if (best_v && best_p < sel_p_r) begin
              sel_n_r <= best_n;
              sel_p_r <= best_p;
            end else begin
              state_r <= ST_RUN;
            end
          end
        end
        ST_UNSTACK: begin
          if (mreq.req && mem_ack) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r == `TVI_LAST_WORD) begin
              sp_r <= sp_r + `TVI_FRAME_BYTES;
              state_r <= (depth_r == 3'h0) ? ST_IDLE : ST_RUN;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Memory requests held until ack, then one idle cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mreq <= '0;
    end else if (mreq.req) begin
      if (mem_ack) mreq.req <= 1'b0;
    end else begin
      case (state_r)
        ST_STACK: mreq <= {1'b1, 1'b1, sp_r + {27'h0, idx_r, 2'b00}, frame_w[idx_r]};
        ST_VFETCH: mreq <= {1'b1, 1'b0, vbase_r + {24'h0, sel_n_r, 2'b00}, 32'h0};
        ST_UNSTACK: mreq <= {1'b1, 1'b0, sp_r + {27'h0, idx_r, 2'b00}, 32'h0};
        default: mreq <= '0;
      endcase
    end
  end

  // Active levels and nesting stack of exception numbers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      act_r <= '0;
      depth_r <= '0;
      exc_num <= '0;
      for (int d = 0; d < DEPTH; d++) exc_stk_r[d] <= '0;
    end else if (accept) begin
      act_r[sel_p_r] <= 1'b1;
      exc_stk_r[depth_r] <= sel_n_r;
      depth_r <= depth_r + 3'h1;
      exc_num <= sel_n_r;
    end else if (state_r == ST_RUN && exc_return) begin
      act_r <= pop_act;
      depth_r <= depth_r - 3'h1;
      exc_num <= (depth_r > 3'h1) ? exc_stk_r[depth_r - 3'h2] : 6'h00;
    end
  end

  assign hnd_mode = (depth_r != 3'h0);

  // Core-facing strobes and data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hnd_start <= 1'b0;
      hnd_addr <= '0;
      rest_vld <= 1'b0;
      rest_idx <= '0;
      rest_data <= '0;
      resume <= 1'b0;
      sp_out <= '0;
    end else begin
      hnd_start <= accept;
      if (accept) hnd_addr <= mem_rdata;
      rest_vld <= (state_r == ST_UNSTACK) && mreq.req && mem_ack;
      if (state_r == ST_UNSTACK && mreq.req && mem_ack) begin
        rest_idx <= idx_r;
        rest_data <= mem_rdata;
      end
      resume <= (state_r == ST_UNSTACK) && mreq.req && mem_ack && idx_r == `TVI_LAST_WORD;
      if (accept) sp_out <= sp_r;
      else if (state_r == ST_UNSTACK && mreq.req && mem_ack && idx_r == `TVI_LAST_WORD)
        sp_out <= sp_r + `TVI_FRAME_BYTES;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_last_push;
    state_r == ST_STACK && mreq.req && mem_ack && idx_r == `TVI_LAST_WORD;
  endsequence
  sequence s_last_pop;
    state_r == ST_UNSTACK && mreq.req && mem_ack && idx_r == `TVI_LAST_WORD;
  endsequence

  a_preempt_only: assert property ((state_r == ST_RUN && !exc_return && !pre_go)
    |=> state_r == ST_RUN)
    else $error("handler left without higher priority request");
  a_vector_addr: assert property (hnd_start |-> hnd_addr == $past(mem_rdata)
    && hnd_mode && $past(mreq.addr) == vbase_r + {24'h0, exc_num, 2'b00})
    else $error("handler address not from the vector table");
  a_stack_write: assert property (state_r == ST_STACK && mreq.req
    |-> mreq.we && mreq.wdata == frame_w[idx_r])
    else $error("stacking access is not a frame write");
  a_stack_fetch: assert property (s_last_push |=> (state_r == ST_VFETCH && !mreq.req)
    ##1 (mreq.req && !mreq.we))
    else $error("vector fetch did not follow stacking");
  a_unstack_resume: assert property (s_last_pop |=> resume && rest_vld
    && rest_idx == `TVI_LAST_WORD)
    else $error("no resume after last restored word");
  a_tail_chain: assert property (state_r == ST_RUN && exc_return && chain_go
    |=> state_r == ST_VFETCH ##1 mreq.req && !mreq.we)
    else $error("pending handler not chained");
  a_late_arrival: assert property (state_r == ST_STACK && best_v && best_p < sel_p_r
    |=> sel_n_r == $past(best_n) && state_r != ST_IDLE)
    else $error("late higher request not taken over");
  a_nmi_first: assert property (nmi_pend_r |-> best_v && best_n == `TVI_EXC_NMI)
    else $error("non-maskable request not selected");
  a_pulse_edge: assert property (|(irq_line & ~irq_d_r & type_r)
    |=> |(pend_r & $past(irq_line & ~irq_d_r & type_r)))
    else $error("pulse request edge not latched");
endmodule // tvi_top

//--- test/tvi_mem_model.sv
// Purpose: Memory behind the interrupt unit's master port
// Assumes: One word access at a time, request held until ack
// Notes: Vector words read back as 0x8000_0000 ORed with their own byte address
`timescale 1ns/1ps
module tvi_mem_model import tvi_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Master port
  input wire tvi_mreq_t mreq,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer delay in cycles
  input wire logic [2:0] dly
);
  logic [31:0] mem [0:255];
  logic [2:0] cnt_r;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'h8000_0000 | 32'(i << 2);
    end
  end
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      // Stale read data is scrambled so a late sample cannot pass
      if (mem_ack) begin
        mem_rdata <= ~mem_rdata;
      end
      if (mreq.req && !mem_ack) begin
        if (cnt_r >= dly) begin
          cnt_r <= 3'h0;
          mem_ack <= 1'b1;
          if (mreq.we) begin
            mem[mreq.addr[9:2]] <= mreq.wdata;
          end else begin
            mem_rdata <= mem[mreq.addr[9:2]];
          end
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end
    end
  end
endmodule // tvi_mem_model

//--- test/tick_timer_and_vectored_irq_test.sv
// Purpose: Register, tick and interrupt entry/exit tests of the unit
// Assumes: Core stack pointer starts at 0x300 and follows sp_out, vector base 0x100
// Notes: Level lines are dropped and their pending bit cleared after entry
`timescale 1ns/1ps
`include "tvi_regs.svh"
module tick_timer_and_vectored_irq_test import tvi_pkg::*; ();
  logic sys_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, nmi_line, ext_tick, exc_return;
  logic hnd_start, hnd_mode, rest_vld, resume, mem_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, irq_line, core_sp, hnd_addr, rest_data, sp_out, mem_rdata;
  logic [31:0] rd, last_psr;
  logic [5:0] exc_num;
  logic [2:0] rest_idx, dly;
  tvi_frame_t core_frame;
  tvi_mreq_t mreq;
  int mismatches, n_checks, n_start, n_rest, r0;

  tvi_top i_dut (.sys_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
    .wb_dat_r, .wb_ack, .irq_line, .nmi_line, .ext_tick, .core_frame, .core_sp, .exc_return,
    .hnd_start, .hnd_addr, .hnd_mode, .exc_num, .rest_vld, .rest_idx, .rest_data, .resume,
    .sp_out, .mreq, .mem_ack, .mem_rdata);
  tvi_mem_model i_mem (.sys_clk, .rst_n, .mreq, .mem_ack, .mem_rdata, .dly);

  function automatic logic [31:0] fw(input int i);
    return 32'h5a00_0000 + 32'(i);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; only the watchdog bounds the wait for ack
  task automatic wb_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge sys_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_acc(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb_acc(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk) ext_tick <= 1'b1;
      @(posedge sys_clk) ext_tick <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wait_hnd(input logic [5:0] e);
    do begin
      @(posedge sys_clk);
    end while (hnd_start !== 1'b1);
    chk({26'h0, exc_num}, {26'h0, e});
    chk(hnd_addr, 32'h8000_0100 + {24'h0, e, 2'b00});
  endtask
  task automatic ret;
    @(posedge sys_clk) exc_return <= 1'b1;
    @(posedge sys_clk) exc_return <= 1'b0;
  endtask
  task automatic wait_res(input logic [31:0] sp);
    do begin
      @(posedge sys_clk);
    end while (resume !== 1'b1);
    chk(sp_out, sp);
    @(posedge sys_clk);
    chk(last_psr, fw(7));
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (hnd_start === 1'b1) n_start++;
    if (rest_vld === 1'b1) begin
      n_rest++;
      if (rest_idx === 3'h7) last_psr = rest_data;
    end
  end
  // Core model: its stack pointer moves to the frame base on entry and back on resume
  always @(posedge sys_clk) begin
    if (rst_n !== 1'b1) begin
      core_sp <= 32'h300;
    end else if (hnd_start === 1'b1 || resume === 1'b1) begin
      core_sp <= sp_out;
    end
  end
  // Whole run takes under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop;
  end

  initial begin
    {rst_n, wb_cyc, wb_stb, wb_we, nmi_line, ext_tick, exc_return} = 7'h0;
    {wb_adr, wb_dat_w, irq_line, dly} = '0;
    wb_sel = 4'hf;
    for (int i = 0; i < 8; i++) core_frame[i*32 +: 32] = fw(i);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk(`TVI_A_VBASE, 32'h0);
    rdchk(`TVI_A_STAT, 32'h0);
    rdchk(8'h3c, 32'h0);
    tdone("reset");
    wr(`TVI_A_TRLD, 32'h5);
    wr(`TVI_A_TCUR, 32'h1234);
    wr(`TVI_A_TCTL, 32'h1);
    tick(3);
    rdchk(`TVI_A_TCUR, 32'h3);
    tick(3);
    rdchk(`TVI_A_TCUR, 32'h0);
    rdchk(`TVI_A_TCTL, 32'h0001_0001);
    rdchk(`TVI_A_TCTL, 32'h1);
    tick(1);
    rdchk(`TVI_A_TCUR, 32'h5);
    wr(`TVI_A_TRLD, 32'h0);
    tick(7);
    rdchk(`TVI_A_TCUR, 32'h0);
    rdchk(`TVI_A_TCTL, 32'h0001_0001);
    wr(`TVI_A_TRLD, 32'hffff_ffff);
    rdchk(`TVI_A_TRLD, 32'h00ff_ffff);
    tick(2);
    rdchk(`TVI_A_TCUR, 32'h00ff_fffe);
    wr(`TVI_A_TCUR, 32'h7);
    rdchk(`TVI_A_TCUR, 32'h0);
    wr(`TVI_A_TCTL, 32'h0);
    wr(`TVI_A_TRLD, 32'h4);
    wr(`TVI_A_TCUR, 32'h0);
    wr(`TVI_A_TCTL, 32'h5);
    repeat (10) @(posedge sys_clk);
    rdchk(`TVI_A_TCTL, 32'h0001_0005);
    tdone("tick");
    wr(`TVI_A_ENSET, 32'ha8);
    wr(`TVI_A_PRLO, 32'hc480);
    rdchk(`TVI_A_PRLO, 32'hc480);
    wr(`TVI_A_TYPE, 32'h20);
    wr(`TVI_A_VBASE, 32'h100);
    wr(`TVI_A_TCTL, 32'h0);
    wr(`TVI_A_TRLD, 32'h2);
    wr(`TVI_A_TCUR, 32'h0);
    wr(`TVI_A_TCTL, 32'h3);
    tick(3);
    wait_hnd(`TVI_EXC_TICK);
    wr(`TVI_A_TCTL, 32'h0);
    ret;
    wait_res(32'h300);
    tdone("tick exception");
    @(posedge sys_clk) irq_line[3] <= 1'b1;
    wait_hnd(6'h13);
    chk(sp_out, 32'h2e0);
    for (int i = 0; i < 8; i++) chk(i_mem.mem[8'hb8 + 8'(i)], fw(i));
    irq_line[3] <= 1'b0;
    wr(`TVI_A_PNCLR, 32'h8);
    chk({31'h0, hnd_mode}, 32'h1);
    r0 = n_start;
    wr(`TVI_A_PNSET, 32'h80);
    repeat (40) @(posedge sys_clk);
    chk(32'(n_start), 32'(r0));
    @(posedge sys_clk) irq_line[5] <= 1'b1;
    @(posedge sys_clk) irq_line[5] <= 1'b0;
    wait_hnd(6'h15);
    ret;
    wait_res(32'h2e0);
    repeat (2) @(posedge sys_clk);
    chk({26'h0, exc_num}, 32'h13);
    r0 = n_rest;
    ret;
    wait_hnd(6'h17);
    chk(32'(n_rest), 32'(r0));
    ret;
    wait_res(32'h300);
    repeat (2) @(posedge sys_clk);
    chk({25'h0, hnd_mode, exc_num}, 32'h0);
    tdone("nesting");
    dly <= 3'h4;
    @(posedge sys_clk) irq_line[3] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    nmi_line <= 1'b1;
    wait_hnd(`TVI_EXC_NMI);
    nmi_line <= 1'b0;
    ret;
    wait_hnd(6'h13);
    irq_line[3] <= 1'b0;
    wr(`TVI_A_PNCLR, 32'h8);
    ret;
    wait_res(32'h300);
    tdone("late arrival");
    report_and_stop;
  end
endmodule // tick_timer_and_vectored_irq_test
